// ==== hdl/btf_consts.svh ====
// Constants for the blit engine: fields, opcodes, register offsets
`ifndef BTF_CONSTS_SVH
`define BTF_CONSTS_SVH
`define BTF_CLIENT 31:29
`define BTF_CLIENT_2D 3'h2
`define BTF_OPC 28:22
`define BTF_OP_GLM 7'h26
`define BTF_OP_GLI 7'h31
`define BTF_OP_SOL 7'h50
`define BTF_OP_PAT 7'h51
`define BTF_LEN 7:0
`define BTF_AMASK 21
`define BTF_CMASK 20
`define BTF_PACK 16
`define BTF_HSEED 14:12
`define BTF_TILE 11
`define BTF_VSEED 10:8
`define BTF_CLIPEN 30
`define BTF_DEPTH 25:24
`define BTF_ROP 23:16
`define BTF_PITCH 15:0
`define BTF_YC 31:16
`define BTF_XC 15:0
`define BTF_CY 30:16
`define BTF_CX 14:0
`define BTF_PAT_MASK 32'h1FFFFFC0
`define BTF_ROP_PCOPY 8'hF0
`define BTF_BYTE_M 32'h7
`define BTF_DW_SH 2
`define BTF_TXW 9
`define BTF_TXH 3
`define BTF_TYW 7
`define BTF_TYH 5
`define BTF_OWS 4
`define BTF_TSH 12
`define BTF_K_SURF 9'h1
`define BTF_K_TL 9'h2
`define BTF_K_BR 9'h3
`define BTF_K_BASE 9'h4
`define BTF_K_ARG 9'h5
`define BTF_K_INL 9'h3
`define BTF_A_CMD 8'h00
`define BTF_A_STAT 8'h04
`define BTF_A_SURF 8'h08
`define BTF_A_BASE 8'h0C
`define BTF_A_BG 8'h10
`define BTF_A_FG 8'h14
`define BTF_A_CTL 8'h18
`define BTF_A_CTL_TL 8'h1C
`define BTF_A_CTL_BR 8'h20
`define BTF_CTL_TRANS 0
`define BTF_CTL_TILEY 1
`endif

// ==== hdl/btf_pkg.sv ====
// Types for the blit engine
package btf_pkg;
  typedef enum logic [2:0] {
    ST_HDR = 3'b000, ST_ARGS = 3'b001, ST_SKIP = 3'b010,
    ST_PIX = 3'b011, ST_RD = 3'b100, ST_WR = 3'b101
  } btf_state_type;
  typedef enum logic [1:0] {RK_SRC = 2'b00, RK_PAT = 2'b01, RK_DST = 2'b10} btf_rdkind_type;
endpackage : btf_pkg

// ==== hdl/btf_blit_engine.sv ====
// Blit engine: glyph expansion, solid fill and pattern fill
//
// Overview of operation
// - Client field 2 addresses this engine
// - Opcode 26h: glyph from memory, 3 dwords
// - Header bit 16 picks bit or byte packing
// - Bit packed rows follow without padding
// - Byte packed rows restart on byte
// - Source byte address maps to top-left
// - Opcode 31h: inline glyph data dwords
// - Glyph writes clipped; colours from setup
// - Opcode 50h solid fill with colour
// - Rop F0 copies colour, fast path
// - 32 bpp alpha and colour lane masks
// - Depth field decodes bytes per pixel
// - Bit 30 enables clip test
// - Signed dword pitch, tiled pitch units
// - Bit 11 selects tiled; CTL bit 1 picks X or Y
// - Corner dwords: signed Y high, X low
// - Opcode 51h colour pattern fill
// - Pattern cell from coordinate plus seed
// - Pattern base uses bits 28:6 only
// - Clip corners are positive 15 bit
// - Transparent mode skips zero source bits
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "btf_consts.svh"
module btf_blit_engine #(
  parameter int INLINE_WORDS = 256
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Surface memory master
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [3:0] mem_be,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Status
  output logic busy,
  output btf_pkg::btf_state_type engine_state
);
  import btf_pkg::*;

  localparam int IAW = $clog2(INLINE_WORDS);

  function automatic logic [1:0] bshift(input logic [1:0] d);
    bshift = (d == 2'h0) ? 2'h0 : ((d == 2'h3) ? 2'h2 : 2'h1);
  endfunction : bshift

  function automatic logic [3:0] lanes(input logic [1:0] d, input logic [1:0] m);
    case (d)
      2'h0: lanes = 4'h1;
      2'h3: lanes = {m[1], m[0], m[0], m[0]};
      default: lanes = 4'h3;
    endcase
  endfunction : lanes

  function automatic logic [31:0] rop3(input logic [7:0] r, input logic [31:0] p, s, d);
    rop3 = 32'h0;
    for (int i = 0; i < 32; i++) begin
      rop3[i] = r[{p[i], s[i], d[i]}];
    end
  endfunction : rop3

  function automatic logic inb(input logic [15:0] v, lo, hi);
    inb = ($signed(v) >= $signed(lo)) && ($signed(v) < $signed(hi));
  endfunction : inb

  function automatic logic [31:0] lo(input logic [31:0] v, input int n);
    lo = v & ((32'h1 << n) - 32'h1);
  endfunction : lo

  function automatic logic [31:0] dst_addr(input logic [31:0] b, input logic [15:0] p, x, y,
                                           input logic [1:0] s, input logic t, ty);
    logic [31:0] bx;
    logic [31:0] yy;
    logic [31:0] pb;
    bx = {16'h0, x} << s;
    yy = {16'h0, y};
    pb = 32'($signed(p)) << `BTF_DW_SH;
    if (!t) begin
      dst_addr = b + yy * pb + bx;
    end else if (!ty) begin
      dst_addr = b + (yy >> `BTF_TXH) * (pb << `BTF_TXH) + ((bx >> `BTF_TXW) << `BTF_TSH)
                 + (lo(yy, `BTF_TXH) << `BTF_TXW) + lo(bx, `BTF_TXW);
    end else begin
      dst_addr = b + (yy >> `BTF_TYH) * (pb << `BTF_TYH) + ((bx >> `BTF_TYW) << `BTF_TSH)
                 + ((lo(bx, `BTF_TYW) >> `BTF_OWS) << (`BTF_TYH + `BTF_OWS))
                 + (lo(yy, `BTF_TYH) << `BTF_OWS) + lo(bx, `BTF_OWS);
    end
  endfunction : dst_addr

  // Setup registers
  logic [31:0] s_surf_q, s_surf_d, s_base_q, s_base_d, bg_q, bg_d, fg_q, fg_d;
  logic [31:0] c_tl_q, c_tl_d, c_br_q, c_br_d, prdata_d;
  logic [1:0] ctl_q, ctl_d;
  // Engine state
  btf_state_type st_q, st_d;
  btf_rdkind_type rk_q, rk_d;
  logic [31:0] hdr_q, hdr_d, surf_q, surf_d, tl_q, tl_d, br_q, br_d, base_q, base_d;
  logic [31:0] arg_q, arg_d, bit_q, bit_d, sw_q, sw_d, swa_q, swa_d, pw_q, pw_d, dw_q, dw_d;
  logic [15:0] x_q, x_d, y_q, y_d;
  logic [8:0] idx_q, idx_d, k;
  logic swv_q, swv_d, pv_q, pv_d, dv_q, dv_d;
  logic req_d, we_d;
  logic [31:0] ad_d, wd_d;
  logic [3:0] be_d;
  logic [31:0] imem [INLINE_WORDS];
  // Decode
  logic sel, acc, wr_cmd, push, hit, iw_en, adv, last;
  logic [6:0] opc;
  logic glyph, gmem, ginl, patc, in_clip, sbit, wr_ok;
  logic [1:0] bs, off;
  logic [2:0] prow, pcol;
  logic [3:0] be0;
  logic [7:0] rop, sbyte;
  logic [31:0] sna, swd, da, pa, pv, sv, res;
  logic [IAW-1:0] ia;

  // APB decode and setup registers
  always_comb begin
    sel = psel && penable;
    acc = (st_q == ST_HDR) || (st_q == ST_ARGS) || (st_q == ST_SKIP);
    wr_cmd = sel && pwrite && (paddr == `BTF_A_CMD);
    pready = !(wr_cmd && !acc);
    push = wr_cmd && acc;
    hit = 1'b1;
    prdata_d = 32'h0;
    case (paddr)
      `BTF_A_CMD: prdata_d = 32'h0;
      `BTF_A_STAT: prdata_d = {28'h0, st_q, busy};
      `BTF_A_SURF: prdata_d = s_surf_q;
      `BTF_A_BASE: prdata_d = s_base_q;
      `BTF_A_BG: prdata_d = bg_q;
      `BTF_A_FG: prdata_d = fg_q;
      `BTF_A_CTL: prdata_d = {30'h0, ctl_q};
      `BTF_A_CTL_TL: prdata_d = c_tl_q;
      `BTF_A_CTL_BR: prdata_d = c_br_q;
      default: hit = 1'b0;
    endcase
    if (!(psel && !penable && !pwrite)) begin
      prdata_d = prdata;
    end
    pslverr = sel && !hit;
    s_surf_d = s_surf_q;
    s_base_d = s_base_q;
    bg_d = bg_q;
    fg_d = fg_q;
    ctl_d = ctl_q;
    c_tl_d = c_tl_q;
    c_br_d = c_br_q;
    if (sel && pwrite) begin
      case (paddr)
        `BTF_A_SURF: s_surf_d = pwdata;
        `BTF_A_BASE: s_base_d = pwdata;
        `BTF_A_BG: bg_d = pwdata;
        `BTF_A_FG: fg_d = pwdata;
        `BTF_A_CTL: ctl_d = pwdata[1:0];
        `BTF_A_CTL_TL: c_tl_d = pwdata;
        `BTF_A_CTL_BR: c_br_d = pwdata;
        default: ctl_d = ctl_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_surf_q <= 32'h0;
      s_base_q <= 32'h0;
      bg_q <= 32'h0;
      fg_q <= 32'h0;
      ctl_q <= 2'h0;
      c_tl_q <= 32'h0;
      c_br_q <= 32'h0;
      prdata <= 32'h0;
    end else begin
      s_surf_q <= s_surf_d;
      s_base_q <= s_base_d;
      bg_q <= bg_d;
      fg_q <= fg_d;
      ctl_q <= ctl_d;
      c_tl_q <= c_tl_d;
      c_br_q <= c_br_d;
      prdata <= prdata_d;
    end
  end

  // Pixel datapath
  always_comb begin
    opc = hdr_q[`BTF_OPC];
    gmem = (opc == `BTF_OP_GLM);
    ginl = (opc == `BTF_OP_GLI);
    glyph = gmem || ginl;
    patc = (opc == `BTF_OP_PAT);
    rop = surf_q[`BTF_ROP];
    bs = bshift(surf_q[`BTF_DEPTH]);
    be0 = lanes(surf_q[`BTF_DEPTH], glyph ? 2'h3 : hdr_q[`BTF_AMASK:`BTF_CMASK]);
    // Clip corners taken as 15 bit positive values
    in_clip = !x_q[15] && !y_q[15] && (!surf_q[`BTF_CLIPEN]
             || (inb(x_q, {1'b0, c_tl_q[`BTF_CX]}, {1'b0, c_br_q[`BTF_CX]})
             && inb(y_q, {1'b0, c_tl_q[`BTF_CY]}, {1'b0, c_br_q[`BTF_CY]})));
    sna = (gmem ? arg_q : 32'h0) + (bit_q >> 3);
    ia = IAW'(sna >> `BTF_DW_SH);
    swd = gmem ? sw_q : imem[ia];
    sbyte = 8'(swd >> {sna[1:0], 3'h0});
    sbit = sbyte[~bit_q[2:0]];
    wr_ok = in_clip && (be0 != 4'h0) && !(glyph && !sbit && ctl_q[`BTF_CTL_TRANS]);
    da = dst_addr(base_q, surf_q[`BTF_PITCH], x_q, y_q, bs, hdr_q[`BTF_TILE],
                  ctl_q[`BTF_CTL_TILEY]);
    off = da[1:0];
    prow = 3'(y_q[2:0] + hdr_q[`BTF_VSEED]);
    pcol = 3'(x_q[2:0] + hdr_q[`BTF_HSEED]);
    pa = (arg_q & `BTF_PAT_MASK) + ({26'h0, prow, pcol} << bs);
    pv = pw_q >> {pa[1:0], 3'h0};
    if (patc) begin
      pv = pw_q >> {pa[1:0], 3'h0};
    end else if (glyph) begin
      pv = bg_q;
    end else begin
      pv = arg_q;
    end
    sv = glyph ? (sbit ? fg_q : bg_q) : 32'h0;
    res = rop3(rop, pv, sv, dw_q >> {off, 3'h0});
  end

  // Command parser and pixel sequencer
  always_comb begin
    st_d = st_q;
    rk_d = rk_q;
    hdr_d = hdr_q;
    surf_d = surf_q;
    tl_d = tl_q;
    br_d = br_q;
    base_d = base_q;
    arg_d = arg_q;
    idx_d = idx_q;
    x_d = x_q;
    y_d = y_q;
    bit_d = bit_q;
    sw_d = sw_q;
    swa_d = swa_q;
    swv_d = swv_q;
    pw_d = pw_q;
    pv_d = pv_q;
    dw_d = dw_q;
    dv_d = dv_q;
    req_d = mem_req;
    we_d = mem_we;
    ad_d = mem_addr;
    wd_d = mem_wdata;
    be_d = mem_be;
    iw_en = 1'b0;
    adv = 1'b0;
    last = (idx_q == ({1'b0, hdr_q[`BTF_LEN]} + 9'h1));
    k = glyph ? idx_q + 9'h1 : idx_q;
    case (st_q)
      ST_HDR: begin
        if (push) begin
          hdr_d = pwdata;
          idx_d = 9'h1;
          surf_d = s_surf_q;
          base_d = s_base_q;
          st_d = ST_SKIP;
          if (pwdata[`BTF_CLIENT] == `BTF_CLIENT_2D && (pwdata[`BTF_OPC] == `BTF_OP_GLM
              || pwdata[`BTF_OPC] == `BTF_OP_GLI || pwdata[`BTF_OPC] == `BTF_OP_SOL
              || pwdata[`BTF_OPC] == `BTF_OP_PAT)) begin
            st_d = ST_ARGS;
          end
        end
      end
      ST_SKIP: begin
        if (push) begin
          idx_d = idx_q + 9'h1;
          if (last) begin
            st_d = ST_HDR;
          end
        end
      end
      ST_ARGS: begin
        if (push) begin
          idx_d = idx_q + 9'h1;
          if (!glyph && k == `BTF_K_SURF) begin
            surf_d = pwdata;
          end
          if (k == `BTF_K_TL) begin
            tl_d = pwdata;
          end
          if (k == `BTF_K_BR) begin
            br_d = pwdata;
          end
          if (!glyph && k == `BTF_K_BASE) begin
            base_d = pwdata;
          end
          if ((!glyph && k == `BTF_K_ARG) || (gmem && k == `BTF_K_BASE)) begin
            arg_d = pwdata;
          end
          iw_en = ginl && (idx_q >= `BTF_K_INL);
          if (last) begin
            x_d = tl_d[`BTF_XC];
            y_d = tl_d[`BTF_YC];
            bit_d = 32'h0;
            swv_d = 1'b0;
            pv_d = 1'b0;
            dv_d = 1'b0;
            st_d = ST_HDR;
            if (inb(tl_d[`BTF_XC], tl_d[`BTF_XC], br_d[`BTF_XC]) &&
                inb(tl_d[`BTF_YC], tl_d[`BTF_YC], br_d[`BTF_YC])) begin
              st_d = ST_PIX;
            end
          end
        end
      end
      ST_PIX: begin
        if (gmem && !(swv_q && swa_q == {sna[31:2], 2'h0})) begin
          req_d = 1'b1;
          we_d = 1'b0;
          ad_d = {sna[31:2], 2'h0};
          rk_d = RK_SRC;
          st_d = ST_RD;
        end else if (!wr_ok) begin
          adv = 1'b1;
        end else if (patc && !pv_q) begin
          req_d = 1'b1;
          we_d = 1'b0;
          ad_d = {pa[31:2], 2'h0};
          rk_d = RK_PAT;
          st_d = ST_RD;
        end else if (rop != `BTF_ROP_PCOPY && !dv_q) begin
          req_d = 1'b1;
          we_d = 1'b0;
          ad_d = {da[31:2], 2'h0};
          rk_d = RK_DST;
          st_d = ST_RD;
        end else begin
          req_d = 1'b1;
          we_d = 1'b1;
          ad_d = {da[31:2], 2'h0};
          wd_d = res << {off, 3'h0};
          be_d = be0 << off;
          st_d = ST_WR;
        end
      end
      ST_RD: begin
        if (mem_ack) begin
          req_d = 1'b0;
          st_d = ST_PIX;
          case (rk_q)
            RK_SRC: begin
              sw_d = mem_rdata;
              swa_d = mem_addr;
              swv_d = 1'b1;
            end
            RK_PAT: begin
              pw_d = mem_rdata;
              pv_d = 1'b1;
            end
            default: begin
              dw_d = mem_rdata;
              dv_d = 1'b1;
            end
          endcase
        end
      end
      ST_WR: begin
        if (mem_ack) begin
          req_d = 1'b0;
          we_d = 1'b0;
          adv = 1'b1;
        end
      end
      default: st_d = ST_HDR;
    endcase
    if (adv) begin
      pv_d = 1'b0;
      dv_d = 1'b0;
      st_d = ST_PIX;
      bit_d = bit_q + 32'h1;
      if (x_q + 16'h1 == br_q[`BTF_XC]) begin
        x_d = tl_q[`BTF_XC];
        y_d = y_q + 16'h1;
        if (hdr_q[`BTF_PACK]) begin
          bit_d = (bit_q + 32'h1 + `BTF_BYTE_M) & ~`BTF_BYTE_M;
        end
        if (y_q + 16'h1 == br_q[`BTF_YC]) begin
          st_d = ST_HDR;
        end
      end else begin
        x_d = x_q + 16'h1;
      end
    end
    busy = (st_q != ST_HDR);
    engine_state = st_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_HDR;
      rk_q <= RK_SRC;
      hdr_q <= 32'h0;
      surf_q <= 32'h0;
      tl_q <= 32'h0;
      br_q <= 32'h0;
      base_q <= 32'h0;
      arg_q <= 32'h0;
      idx_q <= 9'h0;
      x_q <= 16'h0;
      y_q <= 16'h0;
      bit_q <= 32'h0;
      sw_q <= 32'h0;
      swa_q <= 32'h0;
      swv_q <= 1'b0;
      pw_q <= 32'h0;
      pv_q <= 1'b0;
      dw_q <= 32'h0;
      dv_q <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0;
      mem_wdata <= 32'h0;
      mem_be <= 4'h0;
    end else begin
      st_q <= st_d;
      rk_q <= rk_d;
      hdr_q <= hdr_d;
      surf_q <= surf_d;
      tl_q <= tl_d;
      br_q <= br_d;
      base_q <= base_d;
      arg_q <= arg_d;
      idx_q <= idx_d;
      x_q <= x_d;
      y_q <= y_d;
      bit_q <= bit_d;
      sw_q <= sw_d;
      swa_q <= swa_d;
      swv_q <= swv_d;
      pw_q <= pw_d;
      pv_q <= pv_d;
      dw_q <= dw_d;
      dv_q <= dv_d;
      mem_req <= req_d;
      mem_we <= we_d;
      mem_addr <= ad_d;
      mem_wdata <= wd_d;
      mem_be <= be_d;
    end
  end

  // Inline glyph store, filled before drawing starts
  always_ff @(posedge pclk) begin
    if (iw_en && (idx_q - `BTF_K_INL) < 9'(INLINE_WORDS)) begin
      imem[IAW'(idx_q - `BTF_K_INL)] <= pwdata;
    end
  end

endmodule : btf_blit_engine
`default_nettype wire

// ==== test/btf_blit_engine_asserts.sv ====
// Checker for the blit engine ports
`timescale 1ns/1ns
`default_nettype none
`include "btf_consts.svh"
module btf_blit_engine_asserts (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Memory and status
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic mem_ack,
  input wire btf_pkg::btf_state_type engine_state
);
  import btf_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence cmd_access;
    psel && penable && pwrite && paddr == `BTF_A_CMD;
  endsequence
  sequence hdr_taken;
    cmd_access ##0 pready && engine_state == ST_HDR;
  endsequence
  hold_mem_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_be))
    else $error("memory request changed before its answer");
  ack_drop_a: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request held after answer");
  collect_quiet_a: assert property (engine_state inside {ST_HDR, ST_ARGS, ST_SKIP} |-> !mem_req)
    else $error("memory access while collecting a command");
  cmd_stall_a: assert property (cmd_access ##0 engine_state inside {ST_PIX, ST_RD, ST_WR} |-> !pready)
    else $error("command taken while drawing");
  read_ready_a: assert property (psel && penable && !pwrite |-> pready)
    else $error("read not answered at once");
  unmapped_err_a: assert property (psel && penable && paddr > `BTF_A_CTL_BR |-> pslverr)
    else $error("unmapped access not refused");
  client_skip_a: assert property (hdr_taken ##0 pwdata[`BTF_CLIENT] != `BTF_CLIENT_2D |=> engine_state == ST_SKIP)
    else $error("foreign client header not skipped");
  fill_accept_a: assert property (hdr_taken ##0 pwdata[`BTF_CLIENT] == `BTF_CLIENT_2D
    && pwdata[`BTF_OPC] inside {`BTF_OP_SOL, `BTF_OP_PAT} |=> engine_state == ST_ARGS)
    else $error("fill header not accepted");
  dword_align_a: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
    else $error("memory address not dword aligned");
  lane_used_a: assert property (mem_req && mem_we |-> mem_be != 4'h0)
    else $error("write with no byte lane");
endmodule : btf_blit_engine_asserts
bind btf_blit_engine btf_blit_engine_asserts btf_blit_engine_asserts_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_ack, .engine_state);
`default_nettype wire

// ==== test/btf_mem_model.sv ====
// Behavioural surface memory answering the engine's requests
`timescale 1ns/1ns
`default_nettype none
module btf_mem_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] mem_be,
  input wire logic slow,
  // Answers
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [7:0] mem [0:1023];
  logic [1:0] wait_q;
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 8'hEE;
    end
  end
  // Slow mode waits three cycles; idle read data keeps changing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_q <= 2'h0;
    end else if (mem_req && !mem_ack && slow && wait_q != 2'h3) begin
      wait_q <= wait_q + 2'h1;
    end else if (mem_req && !mem_ack) begin
      mem_ack <= 1'b1;
      wait_q <= 2'h0;
      for (int b = 0; b < 4; b++) begin
        mem_rdata[8*b+:8] <= mem[{mem_addr[9:2], 2'(b)}];
        if (mem_we && mem_be[b]) begin
          mem[{mem_addr[9:2], 2'(b)}] <= mem_wdata[8*b+:8];
        end
      end
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : btf_mem_model
`default_nettype wire

// ==== test/btf_blit_engine_tb.sv ====
// Self-checking bench for the blit engine
`timescale 1ns/1ns
`default_nettype none
`include "btf_consts.svh"
module btf_blit_engine_tb;
  import btf_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic pready, pslverr, mem_req, mem_we, mem_ack, busy, err;
  logic [3:0] mem_be;
  btf_state_type engine_state;
  int num_errors = 0, check_count = 0, cyc = 0;
  btf_blit_engine #(.INLINE_WORDS(16)) btf_blit_engine_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be, .mem_ack, .mem_rdata,
    .busy, .engine_state);
  btf_mem_model btf_mem_model_inst (.pclk, .presetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be, .slow,
    .mem_ack, .mem_rdata);
  initial begin
    forever #20 pclk = ~pclk;
  end
  task automatic stop_test;
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      stop_test;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic cmd(input logic [31:0] q[$], input bit wt);
    foreach (q[i]) apb(1'b1, `BTF_A_CMD, q[i]);
    while (wt && busy !== 1'b0) begin
      @(posedge pclk);
    end
  endtask : cmd
  function automatic logic [31:0] hdr(input logic [6:0] op, input logic [21:0] x);
    return {3'h2, op, x};
  endfunction : hdr
  function automatic logic [31:0] mw(input int a);
    return {btf_mem_model_inst.mem[a+3], btf_mem_model_inst.mem[a+2], btf_mem_model_inst.mem[a+1],
      btf_mem_model_inst.mem[a]};
  endfunction : mw
  task automatic t_regs;
    apb(1'b0, `BTF_A_STAT, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b1, `BTF_A_BG, 32'h11);
    apb(1'b0, `BTF_A_BG, 32'h0);
    chk("background", rd, 32'h11);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
  endtask : t_regs
  task automatic t_client;
    cmd('{{3'h3, 7'h50, 22'h4}, 32'h00F00004, 32'h00010001, 32'h00020002, 32'h0E0, 32'h55}, 1);
    chk("foreign client", mw('h0F1), 32'hEEEEEEEE);
  endtask : t_client
  task automatic t_depth;
    logic [31:0] e[4];
    int b, a;
    e = '{32'hEEEEEED4, 32'hEEEEC3D4, 32'hEEEEC3D4, 32'hEEB2C3D4};
    for (int d = 0; d < 4; d++) begin
      b = (d == 0) ? 1 : (d == 3) ? 4 : 2;
      a = 'h100 + d * 'h40;
      cmd('{hdr(7'h50, 22'h100004), 32'h00F00004 | (d << 24), 32'h00010001, 32'h00020002, a, 32'hA1B2C3D4}, 1);
      chk("fill pixel", mw(a + 16 + b), e[d]);
      chk("fill left", {24'h0, btf_mem_model_inst.mem[a + 15 + b]}, 32'hEE);
    end
  endtask : t_depth
  task automatic t_clip;
    apb(1'b1, `BTF_A_CTL_TL, 32'h00000001);
    apb(1'b1, `BTF_A_CTL_BR, 32'h00010003);
    cmd('{hdr(7'h50, 22'h4), 32'h40F00004, 32'h0, 32'h00010004, 32'h200, 32'h77}, 1);
    chk("clipped", mw('h200), 32'hEE7777EE);
    cmd('{hdr(7'h50, 22'h4), 32'h00F00004, 32'h0, 32'h00010004, 32'h200, 32'h66}, 1);
    chk("unclipped", mw('h200), 32'h66666666);
  endtask : t_clip
  task automatic t_tile;
    for (int t = 0; t < 2; t++) begin
      apb(1'b1, `BTF_A_CTL, t << 1);
      cmd('{hdr(7'h50, 22'h804), 32'h00F00008, 32'h00010004, 32'h00020005, 32'h0, 32'h5A + t}, 1);
      chk("tiled pixel", {24'h0, btf_mem_model_inst.mem[t ? 'h14 : 'h204]}, 32'h5A + t);
    end
    chk("linear spot", {24'h0, btf_mem_model_inst.mem['h24]}, 32'hEE);
  endtask : t_tile
  task automatic t_pat;
    for (int i = 0; i < 64; i++) btf_mem_model_inst.mem['h40 + i] = 8'(i);
    slow <= 1'b1;
    cmd('{hdr(7'h51, 22'h3204), 32'h00F00004, 32'h00010001, 32'h00020003, 32'h280, 32'h20000050}, 0);
    cmd('{hdr(7'h50, 22'h4), 32'h00F00004, 32'h0, 32'h00010001, 32'h2C0, 32'h99}, 1);
    chk("pattern", mw('h291), 32'hEEEE1D1C);
    chk("queued fill", mw('h2C0), 32'hEEEEEE99);
    slow <= 1'b0;
  endtask : t_pat
  task automatic t_glyph;
    apb(1'b1, `BTF_A_SURF, 32'h00CC0004);
    apb(1'b1, `BTF_A_FG, 32'h22);
    apb(1'b1, `BTF_A_CTL, 32'h0);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, `BTF_A_BASE, 'h300 + p * 'h40);
      cmd('{hdr(7'h31, p ? 22'h10003 : 22'h3), 32'h0, 32'h00020004, p ? 32'h60A0 : 32'hA6, 32'h0}, 1);
      chk("glyph row0", mw('h300 + p * 'h40), 32'h11221122);
      chk("glyph row1", mw('h310 + p * 'h40), 32'h11222211);
    end
    btf_mem_model_inst.mem['h3C0] = 8'hA6;
    apb(1'b1, `BTF_A_CTL, 32'h1);
    apb(1'b1, `BTF_A_BASE, 32'h380);
    cmd('{hdr(7'h26, 22'h2), 32'h0, 32'h00020004, 32'h3C0}, 1);
    chk("memory glyph row0", mw('h380), 32'hEE22EE22);
    chk("memory glyph row1", mw('h390), 32'hEE2222EE);
  endtask : t_glyph
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_client;
    t_depth;
    t_clip;
    t_tile;
    t_pat;
    t_glyph;
    stop_test;
  end
endmodule : btf_blit_engine_tb
`default_nettype wire
